// [logic/cama_addr_calc.sv]
// Address arithmetic of the addressing mode unit
module cama_addr_calc import cama_pkg::*; (
  input cama_mode_type mode_sel,
  input logic [15:0] opc_addr,
  input logic [7:0] index_reg,
  input logic [7:0] b_hi,
  input logic [7:0] b_lo,
  input logic [7:0] btb_offset,
  output logic [15:0] seq1,
  output logic [15:0] seq2,
  output logic [15:0] seq3,
  output logic [15:0] ea_out,
  output logic [15:0] rel_target,
  output logic [15:0] btb_target
);

  // ----------------------------------------------------------------
  // Sequential addresses and branch targets
  // ----------------------------------------------------------------
  assign seq1 = opc_addr + INSTR_LEN1;
  assign seq2 = opc_addr + INSTR_LEN2;
  assign seq3 = opc_addr + INSTR_LEN3;
  assign rel_target = seq2 + {{8{b_lo[7]}}, b_lo};
  assign btb_target = seq3 + {{8{btb_offset[7]}}, btb_offset};

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_sel)
      MD_DIR: ea_out = {8'h00, b_lo};
      MD_EXT: ea_out = {b_hi, b_lo};
      MD_IX0: ea_out = {8'h00, index_reg};
      MD_IX1: ea_out = {8'h00, index_reg} + {8'h00, b_lo};
      MD_IX2: ea_out = {b_hi, b_lo} + {8'h00, index_reg};
      default: ea_out = {8'h00, b_lo};
    endcase
  end

endmodule // cama_addr_calc

// [logic/cama_core.sv]
// Operand and effective address sequencer with direction registers
// Overview of operation
// - Bit set/clear: bit from opcode, byte address from next byte, page zero.
// - Bit test-and-branch copies the tested bit into carry.
// - Bit test-and-branch: opcode, direct address, signed offset; three bytes.
// - Bit test-and-branch target spans -125 to +130 from opcode.
// - Immediate: byte after opcode is the operand, no further read.
// - Direct: one address byte, lowest 256 bytes, two-byte instruction.
// - Extended: two address bytes reach all memory, three bytes.
// - Relative: signed offset added to counter only when condition true.
// - Relative branch target spans -126 to +129 from opcode.
// - Indexed no offset: index register is the address, one byte.
// - Indexed byte offset: index plus unsigned byte, up to 510.
// - Indexed word offset: index plus unsigned word, three bytes.
// - Inherent instructions are one byte, operands implied.
// - Direction registers are write-only; reads give no real value.
// - Entry level on timer pin at reset release selects bootstrap vector.
module cama_core import cama_pkg::*; (
  input logic clk,
  input logic sys_rst,
  input logic programming_entry_level,
  input logic [7:0] mem_rdata,
  input logic [7:0] index_reg,
  input logic branch_cond,
  input logic fetch_go,
  input logic store_req,
  input logic [7:0] store_data,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [15:0] program_counter,
  output logic [7:0] opcode,
  output cama_mode_type mode,
  output logic [7:0] operand,
  output logic operand_valid,
  output logic [15:0] ea,
  output logic ea_valid,
  output logic carry,
  output logic instr_done,
  output logic boot_mode,
  output logic [7:0] port_a_dir,
  output logic [7:0] port_b_dir,
  output logic [PORT_C_BITS-1:0] port_c_dir
);

  typedef enum logic [7:0] {
    ST_START = 8'h01,
    ST_VEC_HI = 8'h02,
    ST_VEC_LO = 8'h04,
    ST_IDLE = 8'h08,
    ST_OPC = 8'h10,
    ST_B1 = 8'h20,
    ST_B2 = 8'h40,
    ST_RMW = 8'h80
  } cama_state_type;

  function automatic logic cama_is_dir(input logic [15:0] a);
    cama_is_dir = (a == DIR_A_ADDR) || (a == DIR_B_ADDR) ||
      (a == DIR_C_ADDR);
  endfunction

  cama_state_type state;
  cama_state_type next_state;
  cama_mode_type mode_sel;
  logic entry_s1;
  logic entry_s2;
  logic data_ok;
  logic [15:0] opc_addr;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] rd_eff;
  logic tested_bit;
  logic taken;
  logic [15:0] seq1;
  logic [15:0] seq2;
  logic [15:0] seq3;
  logic [15:0] ea_calc;
  logic [15:0] rel_target;
  logic [15:0] btb_target;
  logic rd_go;
  logic wr_go;
  logic [15:0] req_at;
  logic [7:0] wr_val;
  logic pc_go;
  logic [15:0] next_pc;
  logic ea_go;
  logic op_go;
  logic carry_go;
  logic done_go;

  // ----------------------------------------------------------------
  // Timer pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    entry_s1 <= programming_entry_level;
    entry_s2 <= entry_s1;
  end

  // ----------------------------------------------------------------
  // Read data and bit test
  // ----------------------------------------------------------------
  assign rd_eff = cama_is_dir(mem_addr) ? DIR_READ_VAL : mem_rdata;
  assign tested_bit = rd_eff[opcode[3:1]];
  assign taken = tested_bit ^ opcode[0];
  assign mode_sel = (state == ST_OPC) ? cama_decode(rd_eff) : mode;

  cama_addr_calc u_calc (
    .mode_sel(mode_sel),
    .opc_addr(opc_addr),
    .index_reg(index_reg),
    .b_hi(byte1),
    .b_lo(rd_eff),
    .btb_offset(byte2),
    .seq1(seq1),
    .seq2(seq2),
    .seq3(seq3),
    .ea_out(ea_calc),
    .rel_target(rel_target),
    .btb_target(btb_target)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    rd_go = 1'b0;
    wr_go = 1'b0;
    req_at = mem_addr;
    wr_val = 8'h00;
    pc_go = 1'b0;
    next_pc = program_counter;
    ea_go = 1'b0;
    op_go = 1'b0;
    carry_go = 1'b0;
    done_go = 1'b0;
    case (state)
      ST_START: begin
        rd_go = 1'b1;
        req_at = entry_s2 ? BOOT_VEC : RESET_VEC;
        next_state = ST_VEC_HI;
      end
      ST_VEC_HI: if (data_ok) begin
        rd_go = 1'b1;
        req_at = mem_addr + INSTR_LEN1;
        next_state = ST_VEC_LO;
      end
      ST_VEC_LO: if (data_ok) begin
        pc_go = 1'b1;
        next_pc = {byte1, rd_eff};
        next_state = ST_IDLE;
      end
      ST_IDLE: if (fetch_go) begin
        rd_go = 1'b1;
        req_at = program_counter;
        next_state = ST_OPC;
      end else if (store_req) begin
        wr_go = 1'b1;
        req_at = ea;
        wr_val = store_data;
      end
      ST_OPC: if (data_ok) begin
        case (mode_sel)
          MD_INH: begin
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = seq1;
          end
          MD_IX0: begin
            ea_go = 1'b1;
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = seq1;
          end
          default: begin
            rd_go = 1'b1;
            req_at = seq1;
            next_state = ST_B1;
          end
        endcase
      end
      ST_B1: if (data_ok) begin
        case (mode)
          MD_IMM: begin
            op_go = 1'b1;
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = seq2;
          end
          MD_DIR, MD_IX1: begin
            ea_go = 1'b1;
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = seq2;
          end
          MD_REL: begin
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = branch_cond ? rel_target : seq2;
          end
          MD_BSC: begin
            rd_go = 1'b1;
            req_at = {8'h00, rd_eff};
            next_state = ST_RMW;
          end
          MD_EXT, MD_IX2, MD_BTB: begin
            rd_go = 1'b1;
            req_at = seq2;
            next_state = ST_B2;
          end
          default: next_state = ST_IDLE;
        endcase
      end
      ST_B2: if (data_ok) begin
        case (mode)
          MD_EXT, MD_IX2: begin
            ea_go = 1'b1;
            done_go = 1'b1;
            pc_go = 1'b1;
            next_pc = seq3;
          end
          MD_BTB: begin
            rd_go = 1'b1;
            req_at = {8'h00, byte1};
            next_state = ST_RMW;
          end
          default: next_state = ST_IDLE;
        endcase
      end
      ST_RMW: if (data_ok) begin
        done_go = 1'b1;
        pc_go = 1'b1;
        if (mode == MD_BSC) begin
          wr_go = 1'b1;
          wr_val = opcode[0] ? (rd_eff & ~cama_bit_mask(opcode[3:1])) :
            (rd_eff | cama_bit_mask(opcode[3:1]));
          next_pc = seq2;
        end else begin
          carry_go = 1'b1;
          next_pc = taken ? btb_target : seq3;
        end
      end
      default: next_state = ST_START;
    endcase
    if (done_go) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_START;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Memory requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      data_ok <= 1'b0;
    end else begin
      mem_rd <= rd_go;
      mem_wr <= wr_go;
      data_ok <= mem_rd;
      if (rd_go || wr_go) begin
        mem_addr <= req_at;
      end
      if (wr_go) begin
        mem_wdata <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction context
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      program_counter <= 16'h0000;
      opc_addr <= 16'h0000;
      opcode <= 8'h00;
      mode <= MD_INH;
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      boot_mode <= 1'b0;
    end else begin
      if (pc_go) begin
        program_counter <= next_pc;
      end
      if (state == ST_IDLE && fetch_go) begin
        opc_addr <= program_counter;
      end
      if (state == ST_OPC && data_ok) begin
        opcode <= rd_eff;
        mode <= mode_sel;
      end
      if ((state == ST_VEC_HI || state == ST_B1) && data_ok) begin
        byte1 <= rd_eff;
      end
      if (state == ST_B2 && data_ok) begin
        byte2 <= rd_eff;
      end
      if (state == ST_START) begin
        boot_mode <= entry_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ea <= 16'h0000;
      ea_valid <= 1'b0;
      operand <= 8'h00;
      operand_valid <= 1'b0;
      carry <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      ea_valid <= ea_go;
      operand_valid <= op_go;
      instr_done <= done_go;
      if (ea_go) begin
        ea <= ea_calc;
      end
      if (op_go) begin
        operand <= rd_eff;
      end
      if (carry_go) begin
        carry <= tested_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Direction registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_a_dir <= DIR_RESET;
      port_b_dir <= DIR_RESET;
      port_c_dir <= DIR_RESET[PORT_C_BITS-1:0];
    end else if (mem_wr) begin
      if (mem_addr == DIR_A_ADDR) begin
        port_a_dir <= mem_wdata;
      end
      if (mem_addr == DIR_B_ADDR) begin
        port_b_dir <= mem_wdata;
      end
      if (mem_addr == DIR_C_ADDR) begin
        port_c_dir <= mem_wdata[PORT_C_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] pc_delta;
  logic [15:0] rel_off;
  logic rmw_bsc;
  logic rmw_btb;
  logic b1_rel;
  assign pc_delta = program_counter - opc_addr;
  assign rel_off = {{8{rd_eff[7]}}, rd_eff};
  assign rmw_bsc = state == ST_RMW && data_ok && mode == MD_BSC;
  assign rmw_btb = state == ST_RMW && data_ok && mode == MD_BTB;
  assign b1_rel = state == ST_B1 && data_ok && mode == MD_REL;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  bsc_write_a: assert property (rmw_bsc |=> mem_wr &&
    mem_addr[15:8] == 8'h00 && mem_wdata[opcode[3:1]] == ~opcode[0] &&
    (mem_wdata | cama_bit_mask(opcode[3:1])) ==
    ($past(rd_eff) | cama_bit_mask(opcode[3:1])))
    else $error("bit set/clear write wrong");
  carry_copy_a: assert property (rmw_btb |=>
    carry == $past(tested_bit) && instr_done)
    else $error("carry not tested bit");
  btb_skip_a: assert property (rmw_btb && !taken |=>
    program_counter == opc_addr + INSTR_LEN3)
    else $error("untaken bit branch not three bytes on");
  btb_span_a: assert property (rmw_btb && taken |=>
    $signed(pc_delta) >= BTB_BACK && $signed(pc_delta) <= BTB_FWD)
    else $error("bit branch outside span");
  btb_order_a: assert property (state == ST_B1 && data_ok &&
    mode == MD_BTB |=> mem_rd && mem_addr == opc_addr + INSTR_LEN2)
    else $error("bit branch offset byte not read");
  imm_operand_a: assert property (state == ST_B1 && data_ok &&
    mode == MD_IMM |=> operand_valid && operand == $past(rd_eff) &&
    !mem_rd && program_counter == opc_addr + INSTR_LEN2)
    else $error("immediate operand wrong");
  dir_ea_a: assert property (ea_valid && mode == MD_DIR |->
    ea == {8'h00, byte1} && program_counter == opc_addr + INSTR_LEN2)
    else $error("direct address wrong");
  ext_ea_a: assert property (state == ST_B2 && data_ok &&
    mode == MD_EXT |=> ea == {$past(byte1), $past(rd_eff)} &&
    program_counter == opc_addr + INSTR_LEN3)
    else $error("extended address wrong");
  rel_branch_a: assert property (b1_rel |=>
    program_counter == ($past(branch_cond) ?
    opc_addr + INSTR_LEN2 + $past(rel_off) : opc_addr + INSTR_LEN2))
    else $error("relative branch wrong");
  rel_span_a: assert property (b1_rel && branch_cond |=>
    $signed(pc_delta) >= REL_BACK && $signed(pc_delta) <= REL_FWD)
    else $error("relative branch outside span");
  ix0_ea_a: assert property (state == ST_OPC && data_ok &&
    mode_sel == MD_IX0 |=> ea == {8'h00, $past(index_reg)} &&
    program_counter == opc_addr + INSTR_LEN1)
    else $error("indexed no offset wrong");
  ix1_ea_a: assert property (ea_valid && mode == MD_IX1 |->
    ea == {8'h00, byte1} + {8'h00, $past(index_reg)} && ea <= IX1_MAX)
    else $error("byte offset index wrong");
  ix2_ea_a: assert property (state == ST_B2 && data_ok &&
    mode == MD_IX2 |=> ea == {$past(byte1), $past(rd_eff)} +
    {8'h00, $past(index_reg)} && program_counter == opc_addr + INSTR_LEN3)
    else $error("word offset index wrong");
  inh_len_a: assert property (instr_done && mode == MD_INH |->
    program_counter == opc_addr + INSTR_LEN1)
    else $error("inherent length wrong");
  dir_write_a: assert property (mem_wr && mem_addr == DIR_A_ADDR |=>
    port_a_dir == $past(mem_wdata)) else $error("direction store lost");
  boot_vec_a: assert property (state == ST_START |=>
    mem_rd && mem_addr == ($past(entry_s2) ? BOOT_VEC : RESET_VEC))
    else $error("wrong start vector");

  bsc_seen_c: cover property (rmw_bsc);
  btb_taken_c: cover property (rmw_btb && taken);
  rel_taken_c: cover property (b1_rel && branch_cond);
  boot_seen_c: cover property (state == ST_START && entry_s2);

endmodule // cama_core

// [logic/cama_pkg.sv]
// Constants, types and decode helpers of the addressing mode unit
package cama_pkg;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] DIR_A_ADDR = 16'h0004;
  localparam logic [15:0] DIR_B_ADDR = 16'h0005;
  localparam logic [15:0] DIR_C_ADDR = 16'h0006;
  localparam logic [15:0] BOOT_VEC = 16'h07F6;
  localparam logic [15:0] RESET_VEC = 16'h07FE;
  localparam logic [15:0] IX1_MAX = 16'h01FE;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DIR_READ_VAL = 8'hFF;
  localparam int PORT_C_BITS = 4;

  // ----------------------------------------------------------------
  // Instruction lengths and branch spans
  // ----------------------------------------------------------------
  localparam logic [15:0] INSTR_LEN1 = 16'h0001;
  localparam logic [15:0] INSTR_LEN2 = 16'h0002;
  localparam logic [15:0] INSTR_LEN3 = 16'h0003;
  localparam int REL_BACK = -126;
  localparam int REL_FWD = 129;
  localparam int BTB_BACK = -125;
  localparam int BTB_FWD = 130;

  // ----------------------------------------------------------------
  // Opcode groups
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_BTB = 4'h0;
  localparam logic [3:0] NIB_BSC = 4'h1;
  localparam logic [3:0] NIB_REL = 4'h2;
  localparam logic [3:0] NIB_DIR_RMW = 4'h3;
  localparam logic [3:0] NIB_IX1_RMW = 4'h6;
  localparam logic [3:0] NIB_IX0_RMW = 4'h7;
  localparam logic [3:0] NIB_IMM = 4'hA;
  localparam logic [3:0] NIB_DIR = 4'hB;
  localparam logic [3:0] NIB_EXT = 4'hC;
  localparam logic [3:0] NIB_IX2 = 4'hD;
  localparam logic [3:0] NIB_IX1 = 4'hE;
  localparam logic [3:0] NIB_IX0 = 4'hF;
  localparam logic [7:0] OP_SUB_CALL = 8'hAD;

  typedef enum logic [3:0] {
    MD_INH = 4'h0,
    MD_IMM = 4'h1,
    MD_DIR = 4'h2,
    MD_EXT = 4'h3,
    MD_REL = 4'h4,
    MD_IX0 = 4'h5,
    MD_IX1 = 4'h6,
    MD_IX2 = 4'h7,
    MD_BSC = 4'h8,
    MD_BTB = 4'h9
  } cama_mode_type;

  function automatic cama_mode_type cama_decode(input logic [7:0] op);
    case (op[7:4])
      NIB_BTB: cama_decode = MD_BTB;
      NIB_BSC: cama_decode = MD_BSC;
      NIB_REL: cama_decode = MD_REL;
      NIB_DIR_RMW, NIB_DIR: cama_decode = MD_DIR;
      NIB_IX1_RMW, NIB_IX1: cama_decode = MD_IX1;
      NIB_IX0_RMW, NIB_IX0: cama_decode = MD_IX0;
      NIB_IMM: cama_decode = (op == OP_SUB_CALL) ? MD_REL : MD_IMM;
      NIB_EXT: cama_decode = MD_EXT;
      NIB_IX2: cama_decode = MD_IX2;
      default: cama_decode = MD_INH;
    endcase
  endfunction

  function automatic logic [7:0] cama_bit_mask(input logic [2:0] n);
    cama_bit_mask = 8'h01 << n;
  endfunction

endpackage

// [verif/tb_top.sv]
// Self-checking random bench of the addressing mode unit
module tb_top import cama_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, sys_rst, programming_entry_level, branch_cond, fetch_go;
  logic store_req, mem_rd, mem_wr, ea_valid, operand_valid, carry;
  logic instr_done, boot_mode, rd_hold, tk, cexp;
  logic [7:0] mem_rdata, index_reg, store_data, mem_wdata, opcode, operand;
  logic [7:0] port_a_dir, port_b_dir, op, b1, b2, d, off, v, wv;
  logic [3:0] port_c_dir;
  logic [15:0] mem_addr, program_counter, ea, pc, xea;
  logic [7:0] mem [0:65535];
  logic [7:0] dirv [0:2];
  cama_mode_type mode;
  int seed = 66;
  int n_fail, comparisons, cycles, nrd, sel;
  cama_mode_type mtab [0:9] = '{MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IX0,
    MD_IX1, MD_IX2, MD_REL, MD_BSC, MD_BTB};
  int ltab [0:9] = '{1, 2, 2, 3, 1, 2, 3, 2, 2, 3};
  int rtab [0:9] = '{1, 2, 2, 3, 1, 2, 3, 2, 3, 4};

  cama_core u_cama_core (.clk(clk), .sys_rst(sys_rst),
    .programming_entry_level(programming_entry_level),
    .mem_rdata(mem_rdata), .index_reg(index_reg), .branch_cond(branch_cond),
    .fetch_go(fetch_go), .store_req(store_req), .store_data(store_data),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .program_counter(program_counter),
    .opcode(opcode), .mode(mode), .operand(operand),
    .operand_valid(operand_valid), .ea(ea), .ea_valid(ea_valid),
    .carry(carry), .instr_done(instr_done), .boot_mode(boot_mode),
    .port_a_dir(port_a_dir), .port_b_dir(port_b_dir),
    .port_c_dir(port_c_dir));

  // ----------------------------------------------------------------
  // Clock, memory and timeout
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // Read data valid two cycles, then scrambled
  always @(negedge clk) begin
    if (mem_rd === 1'b1) mem_rdata <= mem[mem_addr];
    else if (!rd_hold) mem_rdata <= ~mem_rdata;
    rd_hold <= (mem_rd === 1'b1);
  end

  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] next_pc(input logic [15:0] p,
      input int len, input logic t, input logic [7:0] o);
    next_pc = p + len[15:0] + (t ? {{8{o[7]}}, o} : 16'h0000);
  endfunction

  function automatic logic [7:0] bit_mod(input logic [7:0] x,
      input logic [2:0] n, input logic clr);
    bit_mod = clr ? (x & ~(8'h01 << n)) : (x | (8'h01 << n));
  endfunction

  task automatic check(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic pin, input logic [15:0] vec, st);
    mem[vec] = st[15:8];
    mem[vec + 16'h0001] = st[7:0];
    @(negedge clk);
    sys_rst = 1'b1;
    programming_entry_level = pin;
    repeat (4) @(negedge clk);
    check(port_a_dir, 0, "dir a reset");
    check({port_b_dir, port_c_dir}, 0, "dir bc reset");
    sys_rst = 1'b0;
    repeat (1) @(negedge clk);
    check({mem_rd, mem_addr}, {1'b1, vec}, "vector read");
    repeat (10) @(negedge clk);
    check({boot_mode, program_counter}, {pin, st}, "start");
    pc = st;
    cexp = 1'b0;
    for (int i = 0; i < 3; i++) dirv[i] = 8'h00;
  endtask

  task automatic run_one;
    sel = $unsigned($random(seed)) % 10;
    op = $random(seed);
    b1 = $random(seed);
    b2 = $random(seed);
    d = $random(seed);
    index_reg = $random(seed);
    branch_cond = $random(seed);
    if (sel inside {2, 8, 9} && d[1:0] == 2'd0)
      b1 = (d[3:2] == 2'd3) ? 8'h06 : 8'h04 + {6'h00, d[3:2]};
    if (sel == 5 && d[2]) begin
      index_reg = 8'hFF;
      b1 = 8'hFF;
    end
    case (sel)
      0: op[7:4] = {op[7], ~op[7], 1'b0, op[6]};
      1: op[7:4] = 4'hA;
      2: op[7:4] = {op[7], 3'b011};
      3: op[7:4] = 4'hC;
      4: op[7:4] = {op[7], 3'b111};
      5: op[7:4] = {op[7], 3'b110};
      6: op[7:4] = 4'hD;
      7: op[7:4] = 4'h2;
      8: op[7:4] = 4'h1;
      default: op[7:4] = 4'h0;
    endcase
    if (op == OP_SUB_CALL) op = 8'hA6;
    off = (sel == 7) ? b1 : b2;
    if (d[5:4] == 2'd0) off = 8'h7F;
    if (d[5:4] == 2'd1) off = 8'h80;
    if (pc > 16'h0500) off[7] = 1'b1;
    if (pc < 16'h0300) off[7] = 1'b0;
    if (sel == 7) b1 = off;
    else if (sel == 9) b2 = off;
    v = (b1 inside {8'h04, 8'h05, 8'h06}) ? 8'hFF : mem[{8'h00, b1}];
    tk = (sel == 7) ? branch_cond : (sel == 9) && (v[op[3:1]] ^ op[0]);
    if (sel == 9) cexp = v[op[3:1]];
    case (sel)
      2: xea = {8'h00, b1};
      3: xea = {b1, b2};
      4: xea = {8'h00, index_reg};
      5: xea = {8'h00, b1} + {8'h00, index_reg};
      default: xea = {b1, b2} + {8'h00, index_reg};
    endcase
    mem[pc] = op;
    mem[pc + 16'h0001] = b1;
    mem[pc + 16'h0002] = b2;
    nrd = 0;
    fetch_go = 1'b1;
    @(negedge clk);
    fetch_go = 1'b0;
    for (int i = 0; i < 30; i++) begin
      if (mem_rd === 1'b1) nrd++;
      if (instr_done === 1'b1) break;
      @(negedge clk);
    end
    check(instr_done, 1, "done");
    check(nrd, rtab[sel], "reads");
    check(mode, mtab[sel], "mode");
    check(opcode, op, "opcode");
    check(ea_valid, sel inside {[2:6]}, "ea valid");
    if (sel inside {[2:6]}) check(ea, xea, "ea");
    check(operand_valid, sel == 1, "operand valid");
    if (sel == 1) check(operand, b1, "operand");
    check(carry, cexp, "carry");
    if (sel == 8) begin
      wv = bit_mod(v, op[3:1], op[0]);
      check({mem_wr, mem_addr, mem_wdata}, {1'b1, 8'h00, b1, wv}, "bit");
      if (b1 inside {8'h04, 8'h05, 8'h06}) dirv[b1 - 8'h04] = wv;
    end
    pc = next_pc(pc, ltab[sel], tk, off);
    check(program_counter, pc, "pc");
    if (sel == 2) begin
      store_data = $random(seed);
      store_req = 1'b1;
      @(negedge clk);
      store_req = 1'b0;
      check({mem_wr, mem_addr, mem_wdata}, {1'b1, xea, store_data}, "st");
      if (b1 inside {8'h04, 8'h05, 8'h06}) dirv[b1 - 8'h04] = store_data;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {programming_entry_level, branch_cond, fetch_go, store_req} = 4'h0;
    {index_reg, store_data, mem_rdata} = 24'h00_0000;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rd_hold = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = $random(seed);
    do_reset(1'b1, BOOT_VEC, 16'h0400);
    repeat (120) run_one();
    do_reset(1'b0, RESET_VEC, 16'h0450);
    for (int i = 0; i < 180; i++) begin
      run_one();
      @(negedge clk);
      check({port_a_dir, port_b_dir, port_c_dir},
        {dirv[0], dirv[1], dirv[2][3:0]}, "dirs");
    end
    give_verdict();
  end
endmodule // tb_top
